// file: hdl/hul_pkg.sv
/*
 * Shared constants, types and helpers for the host serial link.
 * Assumes both ends run from one 200 MHz clock domain each.
 */
package hul_pkg;

  // ****************************************
  // Clock and rates
  // ****************************************
  localparam int CLK_HZ = 200000000;
  localparam int BAUD_DEFAULT = 115200;
  localparam int BAUD_MAX = 3000000;
  localparam int DIV_W = 16;
  typedef logic [DIV_W-1:0] hul_div_t;
  typedef logic [7:0] hul_byte_t;
  localparam hul_div_t DIV_DEFAULT =
    hul_div_t'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam hul_div_t DIV_MIN =
    hul_div_t'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
  localparam hul_div_t DIV_ONE = 16'h0001;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam hul_byte_t RATE_CMD = 8'hc3;

  // ****************************************
  // Device register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] REG_TXDATA = 5'h08;
  localparam logic [ADDR_W-1:0] REG_RXDATA = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_DIV = 5'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h18;
  localparam int CTRL_SVC_SET = 0;
  localparam int CTRL_SVC_CLR = 1;
  localparam int IRQ_W = 5;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_RATE = 2;
  localparam int IRQ_HIB = 3;
  localparam int IRQ_ERR = 4;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} hul_bit_e;
  typedef enum logic [1:0] {P_DATA, P_LO, P_HI} hul_parse_e;
  typedef enum logic [1:0] {H_NONE, H_CMD, H_LO, H_HI} hul_seq_e;

  // Limit a requested divisor to the fastest legal rate
  function automatic hul_div_t hul_clamp(input hul_div_t d);
    return (d < DIV_MIN) ? DIV_MIN : d;
  endfunction

endpackage

// file: hdl/hul_link_if.sv
/*
 * Serial link wires between the network processor and its host.
 * Assumes the bench resolves any pull-ups; all signals are plain levels.
 */
interface hul_link_if;
  logic h2d_line;
  logic d2h_line;
  logic host_rts_n;
  logic dev_rts_n;
  logic host_service_request;
  logic hibernate_request_n;

  modport device (
    input h2d_line, host_rts_n, hibernate_request_n,
    output d2h_line, dev_rts_n, host_service_request
  );
  modport host (
    output h2d_line, host_rts_n, hibernate_request_n,
    input d2h_line, dev_rts_n, host_service_request
  );
endinterface

// file: hdl/hul_uart_core.sv
/*
 * 8N1 serial transmitter and receiver, LSB first.
 * Assumes cts_ok is already synchronous; the receive line is not.
 */
module hul_uart_core
  import hul_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Rate
  input wire hul_pkg::hul_div_t div,
  // Transmit side
  input wire logic tx_valid,
  input wire hul_pkg::hul_byte_t tx_data,
  input wire logic cts_ok,
  output logic tx_ready,
  output logic txd,
  // Receive side
  input wire logic rxd,
  output logic rx_valid,
  output hul_pkg::hul_byte_t rx_data,
  output logic rx_ferr
);

  hul_bit_e tx_st;
  hul_div_t tx_div;
  hul_div_t tx_cnt;
  logic [2:0] tx_idx;
  hul_byte_t tx_sh;
  hul_bit_e rx_st;
  hul_div_t rx_div;
  hul_div_t rx_cnt;
  logic [2:0] rx_idx;
  hul_byte_t rx_sh;
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;

  wire tx_tick = (tx_cnt == '0);
  wire rx_tick = (rx_cnt == '0);
  wire hul_div_t tx_next_cnt = tx_tick ? tx_div - DIV_ONE : tx_cnt - DIV_ONE;
  wire hul_div_t rx_next_cnt = rx_tick ? rx_div - DIV_ONE : rx_cnt - DIV_ONE;
  wire tx_start = tx_valid && tx_ready;

  // ****************************************
  // Transmitter
  // ****************************************
  assign tx_ready = (tx_st == S_IDLE) && cts_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st <= S_IDLE;
      txd <= 1'b1;
      tx_div <= DIV_DEFAULT;
      tx_cnt <= '0;
      tx_idx <= '0;
      tx_sh <= '0;
    end else begin
      tx_cnt <= tx_next_cnt;
      case (tx_st)
        S_IDLE: begin
          if (tx_start) begin
            tx_st <= S_START;
            txd <= 1'b0;
            tx_div <= div; // Rate latched per character
            tx_cnt <= div - DIV_ONE;
            tx_sh <= tx_data;
          end
        end
        S_START: begin
          if (tx_tick) begin
            tx_st <= S_DATA;
            txd <= tx_sh[0];
            tx_idx <= '0;
          end
        end
        S_DATA: begin
          if (tx_tick) begin
            if (tx_idx == LAST_BIT) begin
              tx_st <= S_STOP;
              txd <= 1'b1;
            end else begin
              txd <= tx_sh[1];
              tx_sh <= tx_sh >> 1;
              tx_idx <= tx_idx + 3'h1;
            end
          end
        end
        S_STOP: begin
          if (tx_tick) begin
            tx_st <= S_IDLE;
          end
        end
        default: tx_st <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_st <= S_IDLE;
      rx_div <= DIV_DEFAULT;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_sh <= '0;
      rx_valid <= 1'b0;
      rx_data <= '0;
      rx_ferr <= 1'b0;
    end else begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      rx_cnt <= rx_next_cnt;
      rx_valid <= 1'b0;
      rx_ferr <= 1'b0;
      case (rx_st)
        S_IDLE: begin
          if (rx_s3 && !rx_s2) begin
            rx_st <= S_START;
            rx_div <= div;
            rx_cnt <= div >> 1;
          end
        end
        S_START: begin
          if (rx_tick) begin
            rx_st <= rx_s2 ? S_IDLE : S_DATA;
            rx_idx <= '0;
          end
        end
        S_DATA: begin
          if (rx_tick) begin
            rx_sh <= {rx_s2, rx_sh[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == LAST_BIT) begin
              rx_st <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (rx_tick) begin
            rx_st <= S_IDLE;
            rx_valid <= rx_s2;
            rx_ferr <= !rx_s2;
            rx_data <= rx_sh;
          end
        end
        default: rx_st <= S_IDLE;
      endcase
    end
  end

endmodule // hul_uart_core

// file: hdl/hul_device_end.sv
/*
 * Network-processor end of the host serial link, with an
 * Avalon-MM register slave for local software.
 * Assumes the host keeps its own duties on the far side of the link.
 */
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
// Functional notes
// - Link opens at fixed default rate, no autobaud
// - Host command raises rate, at most maximum
// - Service request active high, edge or level
// - Multi-byte fields little-endian, no detection
// - Five wires: data, both handshakes, service
// - Four-wire host stays awake or wakes cleanly
// - Three-wire host accepts unlimited device data
// - Three-wire host awake or lossless start wakeup
// - Service request raised when device must send
// - Low hibernate request puts device in hibernation
module hul_device_end
  import hul_pkg::*;
#(
  parameter bit HOST_FLOW = 1'b1
)
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Avalon-MM slave
  input wire logic [hul_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Status to local logic
  output logic IRQ,
  output logic HIB_ACTIVE,
  // Link
  hul_link_if.device LINK
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic hib_s1;
  logic hib_s2;
  logic hrts_s1;
  logic hrts_s2;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hib_s1 <= 1'b1;
      hib_s2 <= 1'b1;
      hrts_s1 <= 1'b1;
      hrts_s2 <= 1'b1;
    end else begin
      hib_s1 <= LINK.hibernate_request_n;
      hib_s2 <= hib_s1;
      hrts_s1 <= LINK.host_rts_n;
      hrts_s2 <= hrts_s1;
    end
  end

  wire hib = !hib_s2;
  wire host_ready = !HOST_FLOW || !hrts_s2;

  // ****************************************
  // State
  // ****************************************
  hul_div_t div;
  logic tx_full;
  hul_byte_t tx_hold;
  logic rx_full;
  hul_byte_t rx_hold;
  logic svc;
  hul_parse_e pst;
  hul_byte_t div_lo;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic core_ready;
  logic core_rx_v;
  hul_byte_t core_rx_d;
  logic core_ferr;

  hul_uart_core u_core (
    .clk(MCLK),
    .rst_n(ARST_N),
    .div(div),
    .tx_valid(tx_full && !hib),
    .tx_data(tx_hold),
    .cts_ok(host_ready),
    .tx_ready(core_ready),
    .txd(LINK.d2h_line),
    .rxd(LINK.h2d_line),
    .rx_valid(core_rx_v),
    .rx_data(core_rx_d),
    .rx_ferr(core_ferr)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  wire sel_ctrl = (AVS_ADDRESS == REG_CTRL);
  wire sel_tx = (AVS_ADDRESS == REG_TXDATA);
  wire sel_rx = (AVS_ADDRESS == REG_RXDATA);
  wire sel_ist = (AVS_ADDRESS == REG_IRQ_STAT);
  wire sel_imk = (AVS_ADDRESS == REG_IRQ_MASK);
  wire tx_stall = AVS_WRITE && sel_tx && tx_full;
  wire acc = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !tx_stall;
  wire rd = acc && AVS_READ;
  wire wr = acc && AVS_WRITE;
  wire wr_tx = wr && sel_tx;
  wire wr_ctrl = wr && sel_ctrl;
  wire rd_rx = rd && sel_rx;
  wire rd_ist = rd && sel_ist;
  wire [31:0] status_word = {27'h0, svc, hib, rx_full, tx_full, !core_ready};
  wire [31:0] rd_word =
    sel_ctrl ? {31'h0, svc} :
    (AVS_ADDRESS == REG_STATUS) ? status_word :
    sel_rx ? {24'h0, rx_hold} :
    (AVS_ADDRESS == REG_DIV) ? {16'h0, div} :
    sel_ist ? {27'h0, irq_stat} :
    sel_imk ? {27'h0, irq_mask} : 32'h0;

  // ****************************************
  // Receive stream and rate command
  // ****************************************
  wire tx_take = tx_full && !hib && core_ready;
  wire is_cmd = core_rx_v && (pst == P_DATA) && (core_rx_d == RATE_CMD);
  wire deliver = core_rx_v && (pst == P_DATA) && !is_cmd;
  wire rate_set = core_rx_v && (pst == P_HI) && !hib;
  wire overrun = deliver && rx_full && !rd_rx;
  wire next_rx_full = deliver || (rx_full && !rd_rx);
  wire hib_rise = hib && !HIB_ACTIVE;
  wire [IRQ_W-1:0] ev = {core_ferr || overrun, hib_rise, rate_set,
                         tx_take, deliver};
  wire [IRQ_W-1:0] next_irq_stat = (rd_ist ? '0 : irq_stat) | ev;
  wire svc_set = wr_tx || (wr_ctrl && AVS_WRITEDATA[CTRL_SVC_SET]);
  wire svc_clr = core_rx_v || (wr_ctrl && AVS_WRITEDATA[CTRL_SVC_CLR]);
  wire next_svc = svc_set || (svc && !svc_clr);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pst <= P_DATA;
      div_lo <= '0;
      div <= DIV_DEFAULT;
    end else if (hib) begin
      pst <= P_DATA;
      div <= DIV_DEFAULT;
    end else if (core_rx_v) begin
      case (pst)
        P_DATA: pst <= is_cmd ? P_LO : P_DATA;
        P_LO: begin
          div_lo <= core_rx_d; // Low byte first
          pst <= P_HI;
        end
        P_HI: begin
          div <= hul_clamp({core_rx_d, div_lo});
          pst <= P_DATA;
        end
        default: pst <= P_DATA;
      endcase
    end
  end

  // ****************************************
  // Data holding, service request, handshake
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_full <= 1'b0;
      tx_hold <= '0;
      rx_full <= 1'b0;
      rx_hold <= '0;
      svc <= 1'b0;
      LINK.host_service_request <= 1'b0;
      LINK.dev_rts_n <= 1'b1;
      HIB_ACTIVE <= 1'b0;
    end else begin
      tx_full <= wr_tx || (tx_full && !tx_take);
      if (wr_tx) begin
        tx_hold <= AVS_WRITEDATA[7:0];
      end
      rx_full <= next_rx_full;
      if (deliver) begin
        rx_hold <= core_rx_d;
      end
      svc <= next_svc;
      LINK.host_service_request <= !hib && next_svc;
      LINK.dev_rts_n <= next_rx_full || hib;
      HIB_ACTIVE <= hib;
    end
  end

  // ****************************************
  // Bus answer and interrupts
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      IRQ <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= !acc;
      if (rd) begin
        AVS_READDATA <= rd_word;
      end
      if (wr && sel_imk) begin
        irq_mask <= AVS_WRITEDATA[IRQ_W-1:0];
      end
      irq_stat <= next_irq_stat;
      IRQ <= |(irq_stat & irq_mask);
    end
  end

endmodule // hul_device_end

// file: hdl/hul_host_end.sv
/*
 * Host controller end of the serial link.
 * Assumes user logic on the same clock; the link pins are asynchronous.
 */
module hul_host_end
  import hul_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Transmit request
  input wire logic TX_VALID,
  input wire hul_pkg::hul_byte_t TX_DATA,
  output logic TX_READY,
  // Receive data
  output logic RX_VALID,
  output hul_pkg::hul_byte_t RX_DATA,
  input wire logic RX_READY,
  // Rate and power control
  input wire logic RATE_REQ,
  input wire hul_pkg::hul_div_t RATE_DIV,
  input wire logic HIB_REQ,
  output logic SVC_PENDING,
  // Link
  hul_link_if.host LINK
);

  logic drts_s1;
  logic drts_s2;
  logic svc_s1;
  hul_div_t div;
  hul_div_t new_div;
  hul_seq_e seq;
  hul_byte_t tx_hold;
  logic core_ready;
  logic core_rx_v;
  hul_byte_t core_rx_d;

  // ****************************************
  // Byte source selection
  // ****************************************
  wire in_seq = (seq != H_NONE);
  wire hul_byte_t src =
    (seq == H_CMD) ? RATE_CMD :
    (seq == H_LO) ? new_div[7:0] :
    (seq == H_HI) ? new_div[15:8] : tx_hold;
  wire src_v = (in_seq || !TX_READY) && !HIB_REQ;
  wire take = src_v && core_ready;
  wire accept = TX_VALID && TX_READY && !in_seq;
  wire next_rx_v = core_rx_v || (RX_VALID && !RX_READY);

  hul_uart_core u_core (
    .clk(MCLK),
    .rst_n(ARST_N),
    .div(div),
    .tx_valid(src_v),
    .tx_data(src),
    .cts_ok(!drts_s2),
    .tx_ready(core_ready),
    .txd(LINK.h2d_line),
    .rxd(LINK.d2h_line), // Receiver never sleeps
    .rx_valid(core_rx_v),
    .rx_data(core_rx_d),
    .rx_ferr()
  );

  // ****************************************
  // Synchronisers and link controls
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      drts_s1 <= 1'b1;
      drts_s2 <= 1'b1;
      svc_s1 <= 1'b0;
      SVC_PENDING <= 1'b0;
      LINK.hibernate_request_n <= 1'b1;
      LINK.host_rts_n <= 1'b1;
    end else begin
      drts_s1 <= LINK.dev_rts_n;
      drts_s2 <= drts_s1;
      svc_s1 <= LINK.host_service_request;
      SVC_PENDING <= svc_s1;
      LINK.hibernate_request_n <= !HIB_REQ;
      LINK.host_rts_n <= next_rx_v;
    end
  end

  // ****************************************
  // Transmit holding and rate sequence
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_READY <= 1'b1;
      tx_hold <= '0;
      seq <= H_NONE;
      new_div <= DIV_DEFAULT;
      div <= DIV_DEFAULT;
    end else begin
      if (accept) begin
        TX_READY <= 1'b0;
        tx_hold <= TX_DATA;
      end else if (take && !in_seq) begin
        TX_READY <= 1'b1;
      end
      if (HIB_REQ) begin
        seq <= H_NONE;
        div <= DIV_DEFAULT;
      end else begin
        case (seq)
          H_NONE: begin
            if (RATE_REQ && TX_READY && !accept) begin
              seq <= H_CMD;
              new_div <= hul_clamp(RATE_DIV);
            end
          end
          H_CMD: seq <= take ? H_LO : H_CMD;
          H_LO: seq <= take ? H_HI : H_LO;
          H_HI: begin
            if (take) begin
              seq <= H_NONE;
              div <= new_div;
            end
          end
          default: seq <= H_NONE;
        endcase
      end
    end
  end

  // ****************************************
  // Receive holding
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RX_VALID <= 1'b0;
      RX_DATA <= '0;
    end else begin
      RX_VALID <= next_rx_v;
      if (core_rx_v) begin
        RX_DATA <= core_rx_d; // Latest byte kept
      end
    end
  end

endmodule // hul_host_end

// file: tb/hul_link_props.sv
/*
 * Assertions on the host serial link wires.
 * Assumes the bench places it beside the link interface.
 */
module hul_link_props (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Link wires
  input wire logic h2d_line,
  input wire logic d2h_line,
  input wire logic host_rts_n,
  input wire logic dev_rts_n,
  input wire logic host_service_request,
  input wire logic hibernate_request_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Run length of each line level
  // ****************************************
  localparam int MIN_RUN = 66;
  logic h2d_q;
  logic d2h_q;
  logic chg_h;
  logic chg_d;
  logic [7:0] run_h;
  logic [7:0] run_d;
  logic [7:0] next_run_h;
  logic [7:0] next_run_d;

  assign chg_h = h2d_line != h2d_q;
  assign chg_d = d2h_line != d2h_q;
  assign next_run_h = chg_h ? 8'h00 : run_h + {7'h00, run_h != 8'hff};
  assign next_run_d = chg_d ? 8'h00 : run_d + {7'h00, run_d != 8'hff};

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      h2d_q <= 1'b1;
      d2h_q <= 1'b1;
      run_h <= 8'hff;
      run_d <= 8'hff;
    end else begin
      h2d_q <= h2d_line;
      d2h_q <= d2h_line;
      run_h <= next_run_h;
      run_d <= next_run_d;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_host_paused;
    host_rts_n[*8];
  endsequence
  sequence s_dev_paused;
    dev_rts_n[*8];
  endsequence
  sequence s_hib_held;
    !hibernate_request_n[*6];
  endsequence

  a_reset_idle:
    assert property ($rose(ARST_N) |-> h2d_line && d2h_line
      && !host_service_request) else $error("link busy after reset");
  a_bit_run_h:
    assert property (chg_h |-> run_h >= MIN_RUN)
    else $error("host bit too short");
  a_bit_run_d:
    assert property (chg_d |-> run_d >= MIN_RUN)
    else $error("device bit too short");
  a_dev_paused:
    assert property (s_host_paused |-> !(d2h_q && !d2h_line))
    else $error("device sent while host paused");
  a_host_paused:
    assert property (s_dev_paused |-> !(h2d_q && !h2d_line))
    else $error("host sent while device paused");
  a_hib_rts:
    assert property (s_hib_held |-> dev_rts_n)
    else $error("device ready in hibernation");
  a_hib_svc:
    assert property (s_hib_held |-> !host_service_request)
    else $error("service request in hibernation");
  a_hib_quiet:
    assert property (s_hib_held |-> !(d2h_q && !d2h_line))
    else $error("device started byte in hibernation");
  a_svc_level:
    assert property ($rose(host_service_request)
      |-> host_service_request[*4]) else $error("service request glitch");
endmodule // hul_link_props

// file: tb/host_uart_link_tb.sv
/*
 * Self-checking bench: both link ends joined, checker beside them.
 * Assumes a 200 MHz clock and a reset released by the bench.
 */
module host_uart_link_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hul_pkg::*;

  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int TMO = 90000;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic hib_active;
  logic tx_valid = 1'b0;
  hul_byte_t tx_data = '0;
  logic tx_ready;
  logic rx_valid;
  hul_byte_t rx_data;
  logic rx_ready = 1'b0;
  logic rate_req = 1'b0;
  hul_div_t rate_div = DIV_DEFAULT;
  logic hib_req = 1'b0;
  logic svc_pending;
  logic [31:0] rdq;
  hul_byte_t b;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  hul_link_if link ();
  hul_device_end #(.HOST_FLOW(1'b1)) u_hul_device_end (
    .MCLK(mclk), .ARST_N(arst_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq),
    .HIB_ACTIVE(hib_active), .LINK(link.device));
  hul_host_end u_hul_host_end (
    .MCLK(mclk), .ARST_N(arst_n), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_READY(rx_ready), .RATE_REQ(rate_req),
    .RATE_DIV(rate_div), .HIB_REQ(hib_req),
    .SVC_PENDING(svc_pending), .LINK(link.host));
  hul_link_props u_hul_link_props (
    .MCLK(mclk), .ARST_N(arst_n), .h2d_line(link.h2d_line),
    .d2h_line(link.d2h_line), .host_rts_n(link.host_rts_n),
    .dev_rts_n(link.dev_rts_n),
    .host_service_request(link.host_service_request),
    .hibernate_request_n(link.hibernate_request_n));

  always #2.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (cyc == TMO) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_byte(input hul_byte_t got, input hul_byte_t exp);
    cmp_val({24'h0, got}, {24'h0, exp});
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic av_xfer(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < TMO);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic logic lvl(input logic dev);
    return dev ? link.d2h_line : link.h2d_line;
  endfunction

  task automatic get_frame(input logic dev, input int div,
      output hul_byte_t d);
    do @(posedge mclk); while (lvl(dev) !== 1'b0);
    repeat (div - 1) @(posedge mclk);
    cmp_flag(lvl(dev), 1'b0);
    repeat (div / 2 + 1) @(posedge mclk);
    for (int k = 0; k < 8; k++) begin
      d[k] = lvl(dev);
      repeat (div) @(posedge mclk);
    end
    cmp_flag(lvl(dev), 1'b1);
  endtask

  task automatic wait_rx;
    do @(posedge mclk); while (rx_valid !== 1'b1);
  endtask

  task automatic pop_rx;
    @(posedge mclk);
    rx_ready <= 1'b1;
    @(posedge mclk);
    rx_ready <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    repeat (3) @(posedge mclk);
    cmp_flag(link.d2h_line, 1'b1);
    av_xfer(1'b0, REG_DIV, '0, rdq);
    cmp_val(rdq, {16'h0, DIV_DEFAULT});
    av_xfer(1'b1, 5'h1c, 32'hffff_ffff, rdq);
    av_xfer(1'b0, 5'h1c, '0, rdq);
    cmp_val(rdq, 32'h0);
    av_xfer(1'b1, REG_IRQ_MASK, 32'h1f, rdq);
    av_xfer(1'b0, REG_IRQ_MASK, '0, rdq);
    cmp_val(rdq, 32'h1f);
    av_xfer(1'b1, REG_IRQ_MASK, '0, rdq);
    av_xfer(1'b1, REG_CTRL, 32'h1, rdq);
    repeat (2) @(posedge mclk);
    cmp_flag(link.host_service_request, 1'b1);
    av_xfer(1'b1, REG_CTRL, 32'h2, rdq);
    repeat (2) @(posedge mclk);
    cmp_flag(link.host_service_request, 1'b0);
  endtask

  task automatic t_rate;
    @(posedge mclk);
    rate_div <= DIV_MIN;
    rate_req <= 1'b1;
    @(posedge mclk);
    rate_req <= 1'b0;
    get_frame(1'b0, DIV_DEFAULT, b);
    cmp_byte(b, RATE_CMD);
    get_frame(1'b0, DIV_DEFAULT, b);
    cmp_byte(b, DIV_MIN[7:0]);
    get_frame(1'b0, DIV_DEFAULT, b);
    cmp_byte(b, DIV_MIN[15:8]);
    repeat (DIV_DEFAULT) @(posedge mclk);
    av_xfer(1'b0, REG_DIV, '0, rdq);
    cmp_val(rdq, {16'h0, DIV_MIN});
    av_xfer(1'b0, REG_IRQ_STAT, '0, rdq);
    cmp_flag(rdq[IRQ_RATE], 1'b1);
    av_xfer(1'b0, REG_IRQ_STAT, '0, rdq);
    cmp_flag(rdq[IRQ_RATE], 1'b0);
  endtask

  task automatic t_dev_send;
    int n;
    n = 0;
    av_xfer(1'b1, REG_IRQ_MASK, 32'h1 << IRQ_TX, rdq);
    av_xfer(1'b1, REG_TXDATA, 32'ha5, rdq);
    get_frame(1'b1, DIV_MIN, b);
    cmp_byte(b, 8'ha5);
    cmp_flag(link.host_service_request, 1'b1);
    cmp_flag(svc_pending, 1'b1);
    cmp_flag(irq, 1'b1);
    wait_rx();
    repeat (4) @(posedge mclk);
    av_xfer(1'b1, REG_TXDATA, 32'h3c, rdq);
    repeat (20 * DIV_MIN) begin
      @(posedge mclk);
      n += (link.d2h_line !== 1'b1);
    end
    cmp_val(n, 0);
    av_xfer(1'b0, REG_IRQ_STAT, '0, rdq);
    cmp_flag(rdq[IRQ_TX], 1'b1);
    repeat (3) @(posedge mclk);
    cmp_flag(irq, 1'b0);
    cmp_byte(rx_data, 8'ha5);
    pop_rx();
    get_frame(1'b1, DIV_MIN, b);
    cmp_byte(b, 8'h3c);
    wait_rx();
    cmp_byte(rx_data, 8'h3c);
    pop_rx();
    av_xfer(1'b1, REG_IRQ_MASK, '0, rdq);
  endtask

  task automatic t_host_send;
    int n;
    n = 0;
    @(posedge mclk);
    tx_data <= 8'h96;
    tx_valid <= 1'b1;
    @(posedge mclk);
    cmp_flag(tx_ready, 1'b1);
    tx_valid <= 1'b0;
    get_frame(1'b0, DIV_MIN, b);
    cmp_byte(b, 8'h96);
    repeat (DIV_MIN) @(posedge mclk);
    tx_data <= 8'h5a;
    tx_valid <= 1'b1;
    @(posedge mclk);
    tx_valid <= 1'b0;
    repeat (10 * DIV_MIN) begin
      @(posedge mclk);
      n += (link.h2d_line !== 1'b1);
    end
    cmp_val(n, 0);
    av_xfer(1'b0, REG_RXDATA, '0, rdq);
    cmp_val(rdq, 32'h96);
    get_frame(1'b0, DIV_MIN, b);
    cmp_byte(b, 8'h5a);
    repeat (DIV_MIN) @(posedge mclk);
    av_xfer(1'b0, REG_RXDATA, '0, rdq);
    cmp_val(rdq, 32'h5a);
    cmp_flag(link.host_service_request, 1'b0);
  endtask

  task automatic t_hib;
    @(posedge mclk);
    hib_req <= 1'b1;
    repeat (10) @(posedge mclk);
    cmp_flag(link.hibernate_request_n, 1'b0);
    cmp_flag(hib_active, 1'b1);
    cmp_flag(link.dev_rts_n, 1'b1);
    av_xfer(1'b0, REG_DIV, '0, rdq);
    cmp_val(rdq, {16'h0, DIV_DEFAULT});
    av_xfer(1'b0, REG_STATUS, '0, rdq);
    cmp_flag(rdq[3], 1'b1);
    hib_req <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_rate();
    t_dev_send();
    t_host_send();
    t_hib();
    tally_and_finish();
  end
endmodule // host_uart_link_tb
